// ===== dcu_pkg.sv
// Constants, operation codes and saturation helper for the data computation unit
// Overview of operation
// - An accumulator shifts left up to 31 or right up to 32 places, count from temp or instruction.
// - A 16-bit register, memory or I/O operand shifts left up to 31 or right up to 32 places.
// - A 16-bit immediate shifts left by at most 15 places, count always from the instruction.
// - The shifter normalizes, extracts and expands bit fields, counts bits and rotates.
// - An accumulator bound for memory may be rounded, saturated or both before the store.
// - The 40-bit ALU adds, subtracts, compares, rounds, saturates, does logic and absolute value.
// - A dual 16-bit instruction performs two independent 16-bit operations at once.
// - The ALU tests, sets, clears and complements register bits and moves register values.
// - ALU operands come from the instruction buffer side and results go to all other units.
// - Each MAC does a 17x17 fractional or integer multiply plus 40-bit add or subtract in one cycle.
// - The MAC sum may be saturated at 32 or 40 bits as the instruction selects.
// - MAC results are written only to accumulators.
// - Both MACs sustain one dual operation per cycle over three read and two write paths.
// - Four 40-bit accumulators serve as source or destination for the MACs and the ALU.
// - Two 16-bit transition registers collect Viterbi survivor decision bits.
package dcu_pkg;

	localparam int ACC_W   = 40;
	localparam int HALF_W  = 16;
	localparam int NUM_ACC = 4;

	localparam logic [39:0] ACC_RESET  = 40'h00_0000_0000;
	localparam logic [15:0] TRN_RESET  = 16'h0000;
	localparam logic [40:0] ROUND_ADD  = 41'h000_0000_8000;
	localparam logic [40:0] ROUND_MASK = 41'h1FF_FFFF_0000;
	localparam logic [40:0] SAT_MAX40  = 41'h07F_FFFF_FFFF;
	localparam logic [40:0] SAT_MIN40  = 41'h180_0000_0000;
	localparam logic [40:0] SAT_MAX32  = 41'h000_7FFF_FFFF;
	localparam logic [40:0] SAT_MIN32  = 41'h1FF_8000_0000;
	localparam logic [5:0]  NORM_MAX   = 6'h1F;
	localparam logic [5:0]  BIT_LIMIT  = 6'h28;

	typedef enum logic [4:0] {
		OP_NOP      = 5'h00,
		OP_SHIFTACC = 5'h01,
		OP_SHIFTMEM = 5'h02,
		OP_SHIFTIMM = 5'h03,
		OP_NORM     = 5'h04,
		OP_EXTRACT  = 5'h05,
		OP_EXPAND   = 5'h06,
		OP_BITCOUNT = 5'h07,
		OP_ROTATE   = 5'h08,
		OP_STORE    = 5'h09,
		OP_ADD      = 5'h0A,
		OP_SUB      = 5'h0B,
		OP_CMP      = 5'h0C,
		OP_RND      = 5'h0D,
		OP_SAT      = 5'h0E,
		OP_AND      = 5'h0F,
		OP_OR       = 5'h10,
		OP_XOR      = 5'h11,
		OP_ABS      = 5'h12,
		OP_DUALADD  = 5'h13,
		OP_DUALSUB  = 5'h14,
		OP_BITTEST  = 5'h15,
		OP_BITSET   = 5'h16,
		OP_BITCLR   = 5'h17,
		OP_BITNOT   = 5'h18,
		OP_MOVE     = 5'h19,
		OP_MAC      = 5'h1A,
		OP_MSU      = 5'h1B,
		OP_VITERBI  = 5'h1C
	} opcode_t;

	// Clamp a 41-bit signed value to 32 or 40 bits
	function automatic logic [39:0] saturate(input logic [40:0] v, input logic to32);
		logic signed [40:0] hi;
		logic signed [40:0] lo;
		hi = to32 ? SAT_MAX32 : SAT_MAX40;
		lo = to32 ? SAT_MIN32 : SAT_MIN40;
		if ($signed(v) > hi) return hi[39:0];
		if ($signed(v) < lo) return lo[39:0];
		return v[39:0];
	endfunction

endpackage

// ===== dsp_data_computation_unit.sv
// Data computation datapath: shifter, 40-bit ALU, dual MAC, accumulators, transition registers
module dsp_data_computation_unit
	import dcu_pkg::*;
(
	input  wire logic              sys_clk,         // CPU clock
	input  wire logic              resetn,          // Synchronous reset, active low
	input  wire logic              opValid,         // Operation issued this cycle
	input  wire logic [4:0]        opCode,          // Operation code
	input  wire logic [1:0]        dstSel,          // Destination accumulator
	input  wire logic [1:0]        dst2Sel,         // Second MAC destination
	input  wire logic [1:0]        srcSel,          // Source accumulator
	input  wire logic              memSel,          // Second operand from read buses
	input  wire logic signed [5:0] instrCount,      // Shift count from instruction
	input  wire logic              useTempCount,    // Take count from temp register
	input  wire logic signed [5:0] tempCount,       // Temp register shift count
	input  wire logic [5:0]        bitIndex,        // Bit position for bit ops
	input  wire logic              roundEn,         // Round on store
	input  wire logic              satEn,           // Saturate result
	input  wire logic              sat32,           // MAC saturation at 32 bits
	input  wire logic              fracMode,        // MAC fractional format
	input  wire logic              unsignedMode,    // MAC integer unsigned operands
	input  wire logic              trnSel,          // Transition register b selected
	input  wire logic [15:0]       bBus,            // Coefficient read path
	input  wire logic [15:0]       cBus,            // Second data read path
	input  wire logic [15:0]       dBus,            // Single-operand read path
	output logic [3:0][39:0]       accumulatorSet,  // Four accumulators
	output logic [15:0]            viterbiPathRegA, // Transition register a
	output logic [15:0]            viterbiPathRegB, // Transition register b
	output logic [39:0]            resultBus,       // Result to other units
	output logic                   testFlag,        // Compare or bit test outcome
	output logic [15:0]            eBus,            // Store high word
	output logic [15:0]            fBus,            // Store low word
	output logic                   storeValid       // Store words valid, one cycle
);
	opcode_t            op;
	logic [3:0][39:0]   accQ, accD;
	logic [15:0]        trnAQ, trnAD, trnBQ, trnBD;
	logic [39:0]        resultQ, resultD;
	logic               flagQ, flagD, storeQ, storeD;
	logic [15:0]        eQ, eD, fQ, fD;
	logic [39:0]        srcV, dstV, opB, memExt, mac0, mac1;
	logic signed [5:0]  cnt;
	logic [40:0]        sum41, rnd41, st41;
	logic [39:0]        stV;
	logic [15:0]        dLo, dHi, pathA, pathB;
	logic [5:0]         nb;
	logic               decide;

	// Arithmetic shift, positive count left, negative count right
	function automatic logic [39:0] shift40(input logic [39:0] v, input logic signed [5:0] c);
		logic [6:0] mag;
		mag = 7'(-$signed({c[5], c}));
		if (!c[5]) return v << c[4:0];
		return 40'($signed(v) >>> mag);
	endfunction

	// Redundant sign bits below the sign bit
	function automatic logic [5:0] signBits(input logic [39:0] v);
		logic [5:0] n;
		logic       run;
		n = 6'h00;
		run = 1'b1;
		for (int i = 38; i >= 0; i--) begin
			if (run && v[i] == v[39]) n = n + 6'h01;
			else run = 1'b0;
		end
		return n;
	endfunction

	function automatic logic [15:0] fieldExtract(input logic [15:0] v, input logic [15:0] m);
		logic [15:0] r;
		logic [4:0]  k;
		r = 16'h0000;
		k = 5'h00;
		for (int i = 0; i < 16; i++) begin
			if (m[i]) begin
				r[k[3:0]] = v[i];
				k = k + 5'h01;
			end
		end
		return r;
	endfunction

	function automatic logic [15:0] fieldExpand(input logic [15:0] v, input logic [15:0] m);
		logic [15:0] r;
		logic [4:0]  k;
		r = 16'h0000;
		k = 5'h00;
		for (int i = 0; i < 16; i++) begin
			if (m[i]) begin
				r[i] = v[k[3:0]];
				k = k + 5'h01;
			end
		end
		return r;
	endfunction

	function automatic logic [39:0] popCount(input logic [15:0] v);
		logic [39:0] n;
		n = 40'h00_0000_0000;
		for (int i = 0; i < 16; i++) n = n + 40'(v[i]);
		return n;
	endfunction

	// Two lanes fed by three read paths, one dual op per cycle
	mac_unit macLane0 (
		.opA(cBus), .opB(bBus), .unsignedMode(unsignedMode), .fracMode(fracMode),
		.accIn(accQ[dstSel]), .subtract(op == OP_MSU), .satEn(satEn), .sat32(sat32),
		.result(mac0)
	);
	mac_unit macLane1 (
		.opA(dBus), .opB(bBus), .unsignedMode(unsignedMode), .fracMode(fracMode),
		.accIn(accQ[dst2Sel]), .subtract(op == OP_MSU), .satEn(satEn), .sat32(sat32),
		.result(mac1)
	);

	always_comb begin
		op = opcode_t'(opCode);
		srcV = accQ[srcSel];
		dstV = accQ[dstSel];
		memExt = 40'($signed(dBus));
		opB = memSel ? memExt : srcV;
		cnt = useTempCount ? tempCount : instrCount;
		sum41 = {dstV[39], dstV} + {opB[39], opB};
		rnd41 = ({srcV[39], srcV} + ROUND_ADD) & ROUND_MASK;
		st41 = roundEn ? rnd41 : {srcV[39], srcV};
		stV = satEn ? saturate(st41, 1'b1) : st41[39:0];
		nb = signBits(srcV);
		dLo = 16'h0000;
		dHi = 16'h0000;
		pathA = srcV[31:16] + dBus;
		pathB = srcV[15:0] - dBus;
		decide = $signed(pathB) > $signed(pathA);
		accD = accQ;
		trnAD = trnAQ;
		trnBD = trnBQ;
		resultD = resultQ;
		flagD = flagQ;
		eD = eQ;
		fD = fQ;
		storeD = 1'b0;
		if (opValid) begin
			case (op)
				OP_SHIFTACC: accD[dstSel] = shift40(srcV, cnt);
				OP_SHIFTMEM: accD[dstSel] = shift40(memExt, cnt);
				OP_SHIFTIMM: accD[dstSel] = memExt << instrCount[3:0];
				OP_NORM: begin
					accD[dstSel] = shift40(srcV, (nb > NORM_MAX) ? NORM_MAX : nb);
					resultD = 40'(nb);
				end
				OP_EXTRACT: accD[dstSel] = 40'(fieldExtract(srcV[15:0], dBus));
				OP_EXPAND: accD[dstSel] = 40'(fieldExpand(srcV[15:0], dBus));
				OP_BITCOUNT: resultD = popCount(srcV[15:0] & dBus);
				OP_ROTATE: accD[dstSel] = cnt[5] ? {srcV[0], srcV[39:1]} : {srcV[38:0], srcV[39]};
				OP_STORE: begin
					eD = stV[31:16];
					fD = stV[15:0];
					storeD = 1'b1;
				end
				OP_ADD: accD[dstSel] = satEn ? saturate(sum41, 1'b0) : sum41[39:0];
				OP_SUB: begin
					sum41 = {dstV[39], dstV} - {opB[39], opB};
					accD[dstSel] = satEn ? saturate(sum41, 1'b0) : sum41[39:0];
				end
				OP_CMP: flagD = $signed(dstV) < $signed(opB);
				OP_RND: accD[dstSel] = satEn ? saturate(rnd41, 1'b0) : rnd41[39:0];
				OP_SAT: accD[dstSel] = saturate({srcV[39], srcV}, 1'b1);
				OP_AND: accD[dstSel] = dstV & opB;
				OP_OR: accD[dstSel] = dstV | opB;
				OP_XOR: accD[dstSel] = dstV ^ opB;
				OP_ABS: begin
					sum41 = srcV[39] ? 41'h000_0000_0000 - {srcV[39], srcV} : {1'b0, srcV};
					accD[dstSel] = satEn ? saturate(sum41, 1'b0) : sum41[39:0];
				end
				OP_DUALADD, OP_DUALSUB: begin
					opB = memSel ? {8'h00, cBus, dBus} : srcV;
					dLo = (op == OP_DUALADD) ? dstV[15:0] + opB[15:0] : dstV[15:0] - opB[15:0];
					dHi = (op == OP_DUALADD) ? dstV[31:16] + opB[31:16] : dstV[31:16] - opB[31:16];
					accD[dstSel] = {{8{dHi[15]}}, dHi, dLo};
				end
				OP_BITTEST: flagD = (bitIndex < BIT_LIMIT) && dstV[bitIndex];
				OP_BITSET: if (bitIndex < BIT_LIMIT) accD[dstSel][bitIndex] = 1'b1;
				OP_BITCLR: if (bitIndex < BIT_LIMIT) accD[dstSel][bitIndex] = 1'b0;
				OP_BITNOT: if (bitIndex < BIT_LIMIT) accD[dstSel][bitIndex] = ~dstV[bitIndex];
				OP_MOVE: accD[dstSel] = opB;
				OP_MAC, OP_MSU: begin
					accD[dstSel] = mac0;
					accD[dst2Sel] = mac1;
				end
				OP_VITERBI: begin
					accD[dstSel] = {srcV[39:16], decide ? pathB : pathA};
					if (trnSel) trnBD = {trnBQ[14:0], decide};
					else trnAD = {trnAQ[14:0], decide};
				end
				default: ;
			endcase
			if (op != OP_STORE && op != OP_CMP && op != OP_BITTEST && op != OP_NOP &&
				op != OP_NORM && op != OP_BITCOUNT) resultD = accD[dstSel];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			accQ <= {NUM_ACC{ACC_RESET}};
			trnAQ <= TRN_RESET;
			trnBQ <= TRN_RESET;
			resultQ <= ACC_RESET;
			flagQ <= 1'b0;
			eQ <= 16'h0000;
			fQ <= 16'h0000;
			storeQ <= 1'b0;
		end else begin
			accQ <= accD;
			trnAQ <= trnAD;
			trnBQ <= trnBD;
			resultQ <= resultD;
			flagQ <= flagD;
			eQ <= eD;
			fQ <= fD;
			storeQ <= storeD;
		end
	end

	assign accumulatorSet = accQ;
	assign viterbiPathRegA = trnAQ;
	assign viterbiPathRegB = trnBQ;
	assign resultBus = resultQ;
	assign testFlag = flagQ;
	assign eBus = eQ;
	assign fBus = fQ;
	assign storeValid = storeQ;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	immShift_a: assert property (opValid && op == OP_SHIFTIMM |=>
		accQ[$past(dstSel)] == ($past(memExt) << $past(instrCount[3:0])))
		else $error("immediate shift result wrong");
	accShift_a: assert property (opValid && op == OP_SHIFTACC && !cnt[5] |=>
		accQ[$past(dstSel)] == ($past(srcV) << $past(cnt[4:0])))
		else $error("accumulator left shift wrong");
	storeRound_a: assert property (opValid && op == OP_STORE && roundEn && !satEn |=>
		storeValid && eBus == 16'($past(srcV + ROUND_ADD[39:0]) >> 16) && fBus == 16'h0000)
		else $error("rounded store words wrong");
	satRange_a: assert property (opValid && op == OP_SAT |=>
		$signed(accQ[$past(dstSel)]) <= $signed(SAT_MAX32[39:0]) &&
		$signed(accQ[$past(dstSel)]) >= $signed(SAT_MIN32[39:0]))
		else $error("saturated value outside 32-bit range");
	dualLow_a: assert property (opValid && op == OP_DUALADD && !memSel |=>
		accQ[$past(dstSel)][15:0] == 16'($past(dstV[15:0]) + $past(srcV[15:0])))
		else $error("dual add low half wrong");
	bitSet_a: assert property (opValid && op == OP_BITSET && bitIndex < BIT_LIMIT |=>
		accQ[$past(dstSel)][$past(bitIndex)] == 1'b1)
		else $error("bit set failed");
	trnShift_a: assert property (opValid && op == OP_VITERBI && !trnSel |=>
		viterbiPathRegA[15:1] == $past(trnAQ[14:0]) && viterbiPathRegB == $past(trnBQ))
		else $error("transition register shift wrong");
	macDual_a: assert property (opValid && op == OP_MAC && dstSel != dst2Sel |=>
		accQ[$past(dstSel)] == $past(mac0) && accQ[$past(dst2Sel)] == $past(mac1))
		else $error("dual MAC results not written");
	idleHold_a: assert property (!opValid |=> $stable(accQ) && !storeValid)
		else $error("accumulators changed without an operation");
endmodule

// ===== dsp_data_computation_unit_test.sv
// Self-checking bench for the data computation unit
module dsp_data_computation_unit_test
	import dcu_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic              sys_clk = 1'b0, resetn = 1'b0, opValid = 1'b0, memSel = 1'b0;
	logic              useTempCount = 1'b0, roundEn = 1'b0, satEn = 1'b0, sat32 = 1'b0;
	logic              fracMode = 1'b0, unsignedMode = 1'b0, trnSel = 1'b0, rdEn = 1'b0;
	logic [4:0]        opCode = 5'h00;
	logic [1:0]        dstSel = 2'h0, dst2Sel = 2'h0, srcSel = 2'h0;
	logic signed [5:0] instrCount = 6'h00, tempCount = 6'h00;
	logic [5:0]        bitIndex = 6'h00;
	logic [15:0]       bIn = 16'h0000, cIn = 16'h0000, dIn = 16'h0000;
	logic [15:0]       bBus, cBus, dBus, viterbiPathRegA, viterbiPathRegB, eBus, fBus;
	logic [3:0][39:0]  accumulatorSet;
	logic [39:0]       resultBus;
	logic              testFlag, storeValid;
	int                failures = 0, totalChecks = 0;

	always #50 sys_clk = ~sys_clk;

	read_bus_model u_read_bus_model (.sys_clk, .rdEn, .bIn, .cIn, .dIn, .bBus, .cBus, .dBus);

	dsp_data_computation_unit u_dsp_data_computation_unit (
		.sys_clk, .resetn, .opValid, .opCode, .dstSel, .dst2Sel, .srcSel, .memSel,
		.instrCount, .useTempCount, .tempCount, .bitIndex, .roundEn, .satEn, .sat32,
		.fracMode, .unsignedMode, .trnSel, .bBus, .cBus, .dBus, .accumulatorSet,
		.viterbiPathRegA, .viterbiPathRegB, .resultBus, .testFlag, .eBus, .fBus, .storeValid);

	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		totalChecks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic end_sim();
		$display("checks=%0d mismatches=%0d", totalChecks, failures);
		if (failures == 0 && totalChecks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// One issue cycle; valid stays up so calls run back to back
	task automatic issue(input opcode_t c, input logic [1:0] d, input logic [1:0] s,
			input logic m, input logic [5:0] n, input logic [15:0] dd);
		opCode = c;
		dstSel = d;
		srcSel = s;
		memSel = m;
		instrCount = n;
		dIn = dd;
		opValid = 1'b1;
		rdEn = 1'b1;
		@(negedge sys_clk);
	endtask

	// Operation inputs idle for one cycle
	task automatic idle();
		opValid = 1'b0;
		rdEn = 1'b0;
		@(negedge sys_clk);
	endtask

	task automatic t_reset();
		for (int i = 0; i < NUM_ACC; i++) chk(accumulatorSet[i], ACC_RESET);
		chk({8'h00, viterbiPathRegA, viterbiPathRegB}, 40'h00_0000_0000);
		chk({7'h00, storeValid, eBus, fBus}, 40'h00_0000_0000);
		$display("t_reset done");
	endtask

	task automatic t_shift();
		issue(OP_ADD, 2'h0, 2'h0, 1'b1, 6'h00, 16'h4000);
		issue(OP_SHIFTACC, 2'h0, 2'h0, 1'b0, 6'h18, 16'h0000);
		chk(accumulatorSet[0], 40'h40_0000_0000);
		satEn = 1'b1;
		issue(OP_ADD, 2'h0, 2'h0, 1'b0, 6'h00, 16'h0000);
		satEn = 1'b0;
		chk(accumulatorSet[0], 40'h7F_FFFF_FFFF);
		useTempCount = 1'b1;
		tempCount = 6'h20;
		issue(OP_SHIFTACC, 2'h0, 2'h0, 1'b0, 6'h00, 16'h0000);
		useTempCount = 1'b0;
		chk(accumulatorSet[0], 40'h00_0000_007F);
		issue(OP_SHIFTMEM, 2'h1, 2'h1, 1'b1, 6'h3C, 16'h8000);
		chk(accumulatorSet[1], 40'hFF_FFFF_F800);
		issue(OP_SHIFTMEM, 2'h1, 2'h1, 1'b1, 6'h1F, 16'h0001);
		chk(accumulatorSet[1], 40'h00_8000_0000);
		issue(OP_SHIFTIMM, 2'h2, 2'h2, 1'b1, 6'h0F, 16'h0001);
		chk(accumulatorSet[2], 40'h00_0000_8000);
		chk(resultBus, 40'h00_0000_8000);
		$display("t_shift done");
	endtask

	task automatic t_store();
		issue(OP_ADD, 2'h3, 2'h3, 1'b1, 6'h00, 16'h4000);
		issue(OP_SHIFTACC, 2'h3, 2'h3, 1'b0, 6'h18, 16'h0000);
		issue(OP_ADD, 2'h3, 2'h3, 1'b0, 6'h00, 16'h0000);
		chk(accumulatorSet[3], 40'h80_0000_0000);
		satEn = 1'b1;
		issue(OP_STORE, 2'h0, 2'h3, 1'b0, 6'h00, 16'h0000);
		satEn = 1'b0;
		chk({7'h00, storeValid, eBus, fBus}, 40'h01_8000_0000);
		issue(OP_ADD, 2'h2, 2'h2, 1'b1, 6'h00, 16'h1234);
		roundEn = 1'b1;
		issue(OP_STORE, 2'h0, 2'h2, 1'b0, 6'h00, 16'h0000);
		roundEn = 1'b0;
		chk({7'h00, storeValid, eBus, fBus}, 40'h01_0001_0000);
		idle();
		chk({39'h0, storeValid}, 40'h00_0000_0000);
		$display("t_store done");
	endtask

	task automatic t_dual();
		issue(OP_SUB, 2'h1, 2'h1, 1'b0, 6'h00, 16'h0000);
		cIn = 16'h0001;
		issue(OP_DUALADD, 2'h1, 2'h1, 1'b1, 6'h00, 16'hFFFF);
		chk(accumulatorSet[1], 40'h00_0001_FFFF);
		cIn = 16'h0000;
		issue(OP_DUALADD, 2'h1, 2'h1, 1'b1, 6'h00, 16'h0001);
		chk(accumulatorSet[1], 40'h00_0001_0000);
		cIn = 16'h0002;
		issue(OP_DUALSUB, 2'h1, 2'h1, 1'b1, 6'h00, 16'h0001);
		chk(accumulatorSet[1], 40'hFF_FFFF_FFFF);
		issue(OP_DUALADD, 2'h1, 2'h1, 1'b0, 6'h00, 16'h0000);
		chk(accumulatorSet[1], 40'hFF_FFFE_FFFE);
		$display("t_dual done");
	endtask

	task automatic t_mac();
		issue(OP_SUB, 2'h2, 2'h2, 1'b0, 6'h00, 16'h0000);
		issue(OP_SUB, 2'h3, 2'h3, 1'b0, 6'h00, 16'h0000);
		bIn = 16'h7FFF;
		cIn = 16'h7FFF;
		dst2Sel = 2'h3;
		{fracMode, satEn, sat32} = 3'h7;
		issue(OP_MAC, 2'h2, 2'h2, 1'b1, 6'h00, 16'h0003);
		chk(accumulatorSet[2], 40'h00_7FFE_0002);
		chk(accumulatorSet[3], 40'h00_0002_FFFA);
		issue(OP_MAC, 2'h2, 2'h2, 1'b1, 6'h00, 16'h0003);
		chk(accumulatorSet[2], 40'h00_7FFF_FFFF);
		chk(accumulatorSet[3], 40'h00_0005_FFF4);
		{fracMode, satEn, sat32, unsignedMode} = 4'h1;
		bIn = 16'h0002;
		cIn = 16'h0001;
		issue(OP_MSU, 2'h2, 2'h2, 1'b1, 6'h00, 16'hFFFF);
		unsignedMode = 1'b0;
		chk(accumulatorSet[2], 40'h00_7FFF_FFFD);
		chk(accumulatorSet[3], 40'h00_0003_FFF6);
		chk(accumulatorSet[1], 40'hFF_FFFE_FFFE);
		$display("t_mac done");
	endtask

	task automatic t_bits();
		issue(OP_CMP, 2'h2, 2'h3, 1'b0, 6'h00, 16'h0000);
		chk({39'h0, testFlag}, 40'h00_0000_0000);
		issue(OP_CMP, 2'h3, 2'h2, 1'b0, 6'h00, 16'h0000);
		chk({39'h0, testFlag}, 40'h00_0000_0001);
		bitIndex = 6'h27;
		issue(OP_BITSET, 2'h3, 2'h3, 1'b0, 6'h00, 16'h0000);
		chk(accumulatorSet[3], 40'h80_0003_FFF6);
		issue(OP_BITTEST, 2'h3, 2'h3, 1'b0, 6'h00, 16'h0000);
		chk({39'h0, testFlag}, 40'h00_0000_0001);
		issue(OP_BITNOT, 2'h3, 2'h3, 1'b0, 6'h00, 16'h0000);
		bitIndex = 6'h01;
		issue(OP_BITCLR, 2'h3, 2'h3, 1'b0, 6'h00, 16'h0000);
		chk(accumulatorSet[3], 40'h00_0003_FFF4);
		issue(OP_MOVE, 2'h0, 2'h3, 1'b0, 6'h00, 16'h0000);
		chk(accumulatorSet[0], 40'h00_0003_FFF4);
		$display("t_bits done");
	endtask

	task automatic t_viterbi();
		issue(OP_SUB, 2'h0, 2'h0, 1'b0, 6'h00, 16'h0000);
		issue(OP_VITERBI, 2'h0, 2'h0, 1'b1, 6'h00, 16'hFFFF);
		chk({24'h0, viterbiPathRegA}, 40'h00_0000_0001);
		trnSel = 1'b1;
		issue(OP_VITERBI, 2'h0, 2'h0, 1'b1, 6'h00, 16'hFFFF);
		trnSel = 1'b0;
		issue(OP_VITERBI, 2'h0, 2'h0, 1'b1, 6'h00, 16'h0001);
		chk({8'h00, viterbiPathRegA, viterbiPathRegB}, 40'h00_0002_0001);
		chk(accumulatorSet[0], 40'h00_0000_0001);
		$display("t_viterbi done");
	endtask

	task automatic t_misc();
		issue(OP_NORM, 2'h1, 2'h0, 1'b0, 6'h00, 16'h0000);
		chk(accumulatorSet[1], 40'h00_8000_0000);
		chk(resultBus, 40'h00_0000_0026);
		issue(OP_EXTRACT, 2'h1, 2'h3, 1'b0, 6'h00, 16'h00F0);
		chk(accumulatorSet[1], 40'h00_0000_000F);
		issue(OP_EXPAND, 2'h1, 2'h1, 1'b0, 6'h00, 16'h0F00);
		chk(accumulatorSet[1], 40'h00_0000_0F00);
		issue(OP_BITCOUNT, 2'h1, 2'h3, 1'b0, 6'h00, 16'h00FF);
		chk(resultBus, 40'h00_0000_0005);
		issue(OP_ROTATE, 2'h1, 2'h0, 1'b0, 6'h3F, 16'h0000);
		chk(accumulatorSet[1], 40'h80_0000_0000);
		issue(OP_RND, 2'h1, 2'h2, 1'b0, 6'h00, 16'h0000);
		chk(accumulatorSet[1], 40'h00_8000_0000);
		issue(OP_SAT, 2'h1, 2'h1, 1'b0, 6'h00, 16'h0000);
		chk(accumulatorSet[1], 40'h00_7FFF_FFFF);
		issue(OP_AND, 2'h1, 2'h3, 1'b0, 6'h00, 16'h0000);
		chk(accumulatorSet[1], 40'h00_0003_FFF4);
		issue(OP_OR, 2'h1, 2'h0, 1'b0, 6'h00, 16'h0000);
		chk(accumulatorSet[1], 40'h00_0003_FFF5);
		issue(OP_XOR, 2'h1, 2'h2, 1'b0, 6'h00, 16'h0000);
		chk(accumulatorSet[1], 40'h00_7FFC_0008);
		issue(OP_MOVE, 2'h1, 2'h1, 1'b1, 6'h00, 16'h8000);
		chk(accumulatorSet[1], 40'hFF_FFFF_8000);
		issue(OP_ABS, 2'h1, 2'h1, 1'b0, 6'h00, 16'h0000);
		chk(accumulatorSet[1], 40'h00_0000_8000);
		issue(OP_NOP, 2'h3, 2'h3, 1'b0, 6'h00, 16'h0000);
		chk(resultBus, 40'h00_0000_8000);
		chk(accumulatorSet[3], 40'h00_0003_FFF4);
		$display("t_misc done");
	endtask

	initial begin
		#1000000;
		failures++;
		end_sim();
	end

	initial begin
		repeat (10) @(negedge sys_clk);
		resetn = 1'b1;
		t_reset();
		t_shift();
		t_store();
		t_dual();
		t_mac();
		t_bits();
		t_viterbi();
		t_misc();
		end_sim();
	end
endmodule

// ===== mac_unit.sv
// One 17x17 multiply-accumulate lane with optional saturation
module mac_unit
	import dcu_pkg::*;
(
	input  wire logic [15:0] opA,          // First multiplicand
	input  wire logic [15:0] opB,          // Coefficient multiplicand
	input  wire logic        unsignedMode, // Zero-extend operands to 17 bits
	input  wire logic        fracMode,     // Fractional: product doubled
	input  wire logic [39:0] accIn,        // Accumulator addend
	input  wire logic        subtract,     // Subtract product from accumulator
	input  wire logic        satEn,        // Saturate the sum
	input  wire logic        sat32,        // Saturate at 32 instead of 40 bits
	output logic      [39:0] result        // Value bound for an accumulator
);
	logic signed [16:0] a17;
	logic signed [16:0] b17;
	logic signed [33:0] prod;
	logic        [40:0] prod41;
	logic        [40:0] sum41;

	always_comb begin
		a17 = {unsignedMode ? 1'b0 : opA[15], opA};
		b17 = {unsignedMode ? 1'b0 : opB[15], opB};
		prod = a17 * b17;
		prod41 = 41'($signed(prod));
		if (fracMode) prod41 = {prod41[39:0], 1'b0};
		sum41 = subtract ? {accIn[39], accIn} - prod41 : {accIn[39], accIn} + prod41;
		result = satEn ? saturate(sum41, sat32) : sum41[39:0];
	end
endmodule

// ===== read_bus_model.sv
// Operand read path model: three buses valid only in the issue cycle
module read_bus_model (
	input  wire logic        sys_clk, // CPU clock
	input  wire logic        rdEn,    // Operands presented this cycle
	input  wire logic [15:0] bIn,     // Coefficient word
	input  wire logic [15:0] cIn,     // Second data word
	input  wire logic [15:0] dIn,     // Single operand word
	output logic      [15:0] bBus,    // Coefficient read path
	output logic      [15:0] cBus,    // Second read path
	output logic      [15:0] dBus     // Single read path
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [47:0] lastWord_q = 48'h0000_0000_0000;
	always_ff @(posedge sys_clk) begin
		if (rdEn) begin
			lastWord_q <= {bIn, cIn, dIn};
		end
	end
	// Released paths show the inverse of the last words
	assign {bBus, cBus, dBus} = rdEn ? {bIn, cIn, dIn} : ~lastWord_q;
endmodule
